// File: logic/motion_activity_inactivity_detector.sv
// Activity, inactivity, autosleep and motion warning detector
//
// What this block does
// - Wake-up state detects activity on one sample
// - Wake-up activity moves device to measurement
// - Wake-up activity interrupts only when duration zero
// - Awake follows measurement or activity per mode
// - Inactivity needs all enabled axes under threshold
// - X inactivity low byte selects referenced compare
// - Absolute mode compares raw sample against threshold
// - Referenced mode compares against reference from entry
// - Reference refreshed after both go absolute
// - Inactivity timer ticks 32.5 ms, sixteen-bit count
// - Default mode runs both; flags clear on read
// - Linked mode arms at most one detector
// - Linked mode waits for host service
// - Loop mode alternates without host service
// - Autosleep loops between wake-up and measurement
// - Autosleep starts only after host selects wake-up
// - Awake status bit follows mode rules
// - Awake routable to either interrupt pin
// - Independent motion warning threshold sets flag
// - Warning single sample, second pin only
// - Activity any axis over for duration ticks
`timescale 1ns/1ns
`default_nettype none
`include "motion_consts.svh"
module motion_activity_inactivity_detector
#(
  parameter logic [`TICK_W-1:0] ACT_TICK_CYC =
    `TICK_W'(`ACT_TICK_NS / `CLK_PERIOD_NS),
  parameter logic [`TICK_W-1:0] ACT_TICK_FAST_CYC =
    `TICK_W'(`ACT_TICK_FAST_NS / `CLK_PERIOD_NS),
  parameter logic [`TICK_W-1:0] INACT_TICK_CYC =
    `TICK_W'(`INACT_TICK_NS / `CLK_PERIOD_NS)
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Sample stream
  input wire logic sample_valid,
  input wire motion_pkg::sample_s sample,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Interrupt pins and power state
  output logic irq_pin_one,
  output logic irq_pin_two,
  output logic [2:0] pwr_mode
);

  // *****************************
  // Helper functions
  // *****************************
  // Byte of the configuration window at a fixed address
  function automatic logic [7:0] cfg_at(input logic [`CFG_N-1:0][7:0] c,
                                        input logic [7:0] a);
    logic [7:0] i;
    i = a - `CFG_BASE;
    return c[i[5:0]];
  endfunction

  // Enable bit and eleven-bit threshold of one axis
  function automatic logic [11:0] th_of(input logic [`CFG_N-1:0][7:0] c,
                                        input logic [7:0] base,
                                        input logic [1:0] ax);
    logic [7:0] hi;
    logic [7:0] lo;
    hi = cfg_at(c, base + {5'h00, ax, 1'b0});
    lo = cfg_at(c, base + {5'h00, ax, 1'b1});
    return {lo[`TH_EN_BIT], hi, lo[7:5]};
  endfunction

  // Magnitude of sample or of its deviation from the reference
  function automatic logic [12:0] mag(input logic [11:0] s,
                                      input logic [11:0] r,
                                      input logic rel);
    logic signed [12:0] d;
    d = rel ? ($signed({s[11], s}) - $signed({r[11], r}))
            : $signed({s[11], s});
    return d[12] ? 13'(-d) : 13'(d);
  endfunction

  motion_pkg::det_s q;
  motion_pkg::det_s n;
  logic act_tick;
  logic inact_tick;

  // Decoded configuration and events
  logic [7:0] act_time;
  logic [15:0] inact_time;
  logic [7:0] mode_b;
  logic [7:0] map1;
  logic [7:0] map2;
  logic act_rel;
  logic inact_rel;
  logic autosleep;
  logic lp;
  logic lk;
  logic dflt;
  logic follow_pwr;
  logic arm_act;
  logic arm_inact;
  logic over_a;
  logic inact_ok;
  logic warn_over;
  logic wake_act;
  logic meas_act;
  logic inact_evt;
  logic rd_st2;
  logic pwr_wr;

  // *****************************
  // Tick timers
  // *****************************
  // Activity period halves at the fast sample rate
  motion_tick act_timer
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clear(!q.act_run),
    .limit(((cfg_at(q.cfg, `ADDR_POWER) >> `ODR_FAST_BIT) & 8'h01) != 8'h00
           ? ACT_TICK_FAST_CYC : ACT_TICK_CYC),
    .tick(act_tick)
  );

  // Inactivity period is fixed whatever the rate
  motion_tick inact_timer
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clear(!q.inact_run),
    .limit(INACT_TICK_CYC),
    .tick(inact_tick)
  );

  // *****************************
  // Decode and compare
  // *****************************
  always_comb
  begin
    logic [11:0] ta;
    logic [11:0] ti;
    logic [11:0] tw;
    logic [7:0] xl;
    logic any_en;
    ta = '0;
    ti = '0;
    tw = '0;
    xl = '0;
    any_en = 1'b0;
    act_time = cfg_at(q.cfg, `ADDR_ACT_TIME);
    inact_time = {cfg_at(q.cfg, `ADDR_INACT_TIME_H),
                  cfg_at(q.cfg, `ADDR_INACT_TIME_L)};
    mode_b = cfg_at(q.cfg, `ADDR_ACT_MODE);
    map1 = cfg_at(q.cfg, `ADDR_IRQ_PIN_ONE_MAP);
    map2 = cfg_at(q.cfg, `ADDR_IRQ_PIN_TWO_MAP);
    xl = cfg_at(q.cfg, `ACT_TH_BASE + 8'h01);
    act_rel = xl[`TH_REL_BIT];
    xl = cfg_at(q.cfg, `INACT_TH_BASE + 8'h01);
    inact_rel = xl[`TH_REL_BIT];
    autosleep = mode_b[`AUTOSLEEP_BIT];
    // Autosleep behaves as loop only once the host chose wake-up
    lp = mode_b[`MODE_LOOP_BIT] || (autosleep && q.as_armed);
    lk = !lp && mode_b[`MODE_LINK_BIT];
    dflt = !lp && !lk;
    follow_pwr = dflt || autosleep;
    // Linked mode holds the next detector until the flag is read
    arm_act = dflt || (q.phase == motion_pkg::PH_ACT
                       && !(lk && q.inact_f));
    arm_inact = (q.pwr == motion_pkg::PWR_MEAS)
                && (dflt || (q.phase == motion_pkg::PH_INACT
                             && !(lk && q.act_f)));
    over_a = 1'b0;
    warn_over = 1'b0;
    inact_ok = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      ta = th_of(q.cfg, `ACT_TH_BASE, 2'(i));
      ti = th_of(q.cfg, `INACT_TH_BASE, 2'(i));
      tw = th_of(q.cfg, `WARN_TH_BASE, 2'(i));
      // Any one enabled axis over its threshold is activity
      over_a = over_a || (ta[11] && mag(sample.axis[i], q.refv[i], act_rel)
                          > {2'h0, ta[10:0]});
      // Warning shares the activity reference selection
      warn_over = warn_over || (tw[11] && mag(sample.axis[i], q.refv[i],
                                act_rel) > {2'h0, tw[10:0]});
      any_en = any_en || ti[11];
      // Every enabled axis must sit under its own threshold
      inact_ok = inact_ok && (!ti[11] || mag(sample.axis[i], q.refv[i],
                              inact_rel) < {2'h0, ti[10:0]});
    end
    inact_ok = inact_ok && any_en;
    // Single sample in wake-up, duration ignored
    wake_act = sample_valid && q.pwr == motion_pkg::PWR_WAKE
               && arm_act && over_a;
    meas_act = sample_valid && q.pwr == motion_pkg::PWR_MEAS && arm_act
               && over_a && q.act_cnt >= act_time;
    inact_evt = sample_valid && arm_inact && inact_ok
                && q.inact_cnt >= inact_time;
    rd_st2 = reg_rd && reg_addr == `ADDR_STATUS2;
    pwr_wr = reg_wr && reg_addr == `ADDR_POWER;
  end

  // *****************************
  // Next state
  // *****************************
  always_comb
  begin
    logic [7:0] rb;
    rb = '0;
    n = q;
    n.rvalid = 1'b0;
    // Duration counters advance per tick of an unbroken run
    if (act_tick && q.act_run && q.act_cnt != `ACT_CNT_MAX)
    begin
      n.act_cnt = q.act_cnt + 8'h01;
    end
    if (inact_tick && q.inact_run && q.inact_cnt != `INACT_CNT_MAX)
    begin
      n.inact_cnt = q.inact_cnt + 16'h0001;
    end
    // Activity timer only runs in measurement
    if (q.pwr != motion_pkg::PWR_MEAS || (sample_valid
        && (!(arm_act && over_a) || meas_act)))
    begin
      n.act_run = 1'b0;
      n.act_cnt = '0;
    end
    else if (sample_valid)
    begin
      n.act_run = 1'b1;
    end
    // A failing sample or an event restarts the inactivity run
    if (!arm_inact || (sample_valid && (!inact_ok || inact_evt)))
    begin
      n.inact_run = 1'b0;
      n.inact_cnt = '0;
    end
    else if (sample_valid)
    begin
      n.inact_run = 1'b1;
    end
    // Sticky flags; a new event beats the read that clears
    n.act_f = meas_act || (wake_act && act_time == 8'h00)
              || (q.act_f && !rd_st2);
    n.inact_f = inact_evt || (q.inact_f && !rd_st2);
    n.warn_f = (sample_valid && q.pwr != motion_pkg::PWR_STBY && warn_over)
               || (q.warn_f && !rd_st2);
    // Alternation between detectors
    if (wake_act || meas_act)
    begin
      n.phase = motion_pkg::PH_INACT;
    end
    if (inact_evt)
    begin
      n.phase = motion_pkg::PH_ACT;
    end
    if (wake_act)
    begin
      n.pwr = motion_pkg::PWR_MEAS;
    end
    // Only an armed autosleep returns to wake-up
    if (inact_evt && autosleep && q.as_armed)
    begin
      n.pwr = motion_pkg::PWR_WAKE;
    end
    // Configuration writes; the power command overrides auto moves
    if (reg_wr && reg_addr >= `CFG_BASE && reg_addr <= `CFG_LAST)
    begin
      n.cfg[6'(reg_addr - `CFG_BASE)] = reg_wdata;
    end
    if (pwr_wr)
    begin
      unique case (reg_wdata[1:0])
        `PWR_CODE_WAKE:
        begin
          n.pwr = motion_pkg::PWR_WAKE;
          n.as_armed = 1'b1;
          n.phase = motion_pkg::PH_ACT;
        end
        `PWR_CODE_MEAS:
        begin
          n.pwr = motion_pkg::PWR_MEAS;
          n.as_armed = 1'b0;
        end
        default:
        begin
          n.pwr = motion_pkg::PWR_STBY;
          n.as_armed = 1'b0;
        end
      endcase
    end
    // Reference is taken on the first sample after entering measurement
    if (n.pwr == motion_pkg::PWR_MEAS && q.pwr != motion_pkg::PWR_MEAS)
    begin
      n.ref_pend = !q.ref_held;
    end
    if (sample_valid && q.ref_pend && q.pwr == motion_pkg::PWR_MEAS
        && (act_rel || inact_rel))
    begin
      n.refv = sample.axis;
      n.ref_pend = 1'b0;
      n.ref_held = 1'b1;
    end
    // Both detectors absolute again lets the next entry recapture
    if (!act_rel && !inact_rel)
    begin
      n.ref_held = 1'b0;
    end
    // Awake status
    if (follow_pwr)
    begin
      n.awake = n.pwr == motion_pkg::PWR_MEAS;
    end
    else if (inact_evt)
    begin
      n.awake = 1'b0;
    end
    else if (meas_act || (wake_act && act_time == 8'h00))
    begin
      n.awake = 1'b1;
    end
    // Pins as levels; warning only reaches the second pin
    n.pin1 = (map1[`MAP_ACT] && n.act_f) || (map1[`MAP_INACT] && n.inact_f)
             || (map1[`MAP_AWAKE] && n.awake);
    n.pin2 = (map2[`MAP_ACT] && n.act_f) || (map2[`MAP_INACT] && n.inact_f)
             || (map2[`MAP_AWAKE] && n.awake)
             || (map2[`MAP_WARN] && n.warn_f);
    // Read answer one cycle after the strobe
    if (reg_rd)
    begin
      n.rvalid = 1'b1;
      if (reg_addr == `ADDR_STATUS)
      begin
        rb[`AWAKE_BIT] = q.awake;
      end
      else if (reg_addr == `ADDR_STATUS2)
      begin
        rb[`ST2_ACT_BIT] = q.act_f;
        rb[`ST2_INACT_BIT] = q.inact_f;
        rb[`ST2_WARN_BIT] = q.warn_f;
      end
      else if (reg_addr == `ADDR_POWER)
      begin
        rb = cfg_at(q.cfg, `ADDR_POWER);
        rb[1:0] = q.pwr == motion_pkg::PWR_MEAS ? `PWR_CODE_MEAS :
                  q.pwr == motion_pkg::PWR_WAKE ? `PWR_CODE_WAKE :
                  `PWR_CODE_STBY;
      end
      else if (reg_addr >= `CFG_BASE && reg_addr <= `CFG_LAST)
      begin
        rb = q.cfg[6'(reg_addr - `CFG_BASE)];
      end
      n.rdata = rb;
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.pwr <= motion_pkg::PWR_STBY;
      q.phase <= motion_pkg::PH_ACT;
    end
    else
    begin
      q <= n;
    end
  end

  assign reg_rdata = q.rdata;
  assign reg_rvalid = q.rvalid;
  assign irq_pin_one = q.pin1;
  assign irq_pin_two = q.pin2;
  assign pwr_mode = q.pwr;

  // *****************************
  // Checks
  // *****************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Wake-up hit with no power command in the same cycle
  sequence s_wake_hit;
    wake_act && !pwr_wr;
  endsequence

  // Armed autosleep reaching inactivity
  sequence s_sleep;
    inact_evt && autosleep && q.as_armed && !pwr_wr;
  endsequence

  wake_single_a: assert property (
    s_wake_hit ##0 act_time == 8'h00
    |=> q.act_f && q.pwr == motion_pkg::PWR_MEAS)
    else $error("wake-up activity did not fire");
  wake_move_a: assert property (
    s_wake_hit |=> q.pwr == motion_pkg::PWR_MEAS)
    else $error("wake-up activity did not enter measurement");
  wake_gate_a: assert property (
    s_wake_hit ##0 (act_time != 8'h00 && !q.act_f) |=> !q.act_f)
    else $error("wake-up activity raised flag with duration set");
  awake_pwr_a: assert property (
    follow_pwr |=> q.awake == (q.pwr == motion_pkg::PWR_MEAS))
    else $error("awake not following measurement");
  one_armed_a: assert property (
    !dflt |-> !(arm_act && arm_inact))
    else $error("both detectors armed");
  linked_hold_a: assert property (
    (lk && q.act_f) |-> !arm_inact)
    else $error("linked mode armed before service");
  inact_rst_a: assert property (
    (sample_valid && !inact_ok)
    |=> q.inact_cnt == 16'h0000 && !q.inact_run)
    else $error("inactivity run not restarted");
  inact_evt_a: assert property (
    inact_evt |-> inact_ok && q.inact_cnt >= inact_time
    && q.pwr == motion_pkg::PWR_MEAS)
    else $error("inactivity without qualifying run");
  sleep_back_a: assert property (
    s_sleep |=> q.pwr == motion_pkg::PWR_WAKE
    && q.phase == motion_pkg::PH_ACT)
    else $error("autosleep did not return to wake-up");
  no_sleep_a: assert property (
    (!q.as_armed && inact_evt && !pwr_wr && q.pwr == motion_pkg::PWR_MEAS)
    |=> q.pwr == motion_pkg::PWR_MEAS)
    else $error("left measurement without armed autosleep");
  warn_set_a: assert property (
    (sample_valid && warn_over && q.pwr != motion_pkg::PWR_STBY)
    |=> q.warn_f)
    else $error("warning flag not set");

endmodule
`default_nettype wire

// File: inc/motion_consts.svh
// Constants for the motion activity and inactivity detector
`ifndef MOTION_CONSTS_SVH
`define MOTION_CONSTS_SVH

// Timing
`define CLK_PERIOD_NS 10
`define ACT_TICK_NS 8250000
`define ACT_TICK_FAST_NS 4125000
`define INACT_TICK_NS 32500000
`define TICK_W 24
`define TICK_ONE 24'h000001

// Register offsets
`define ADDR_STATUS 8'h04
`define ADDR_STATUS2 8'h05
`define ACT_TH_BASE 8'h23
`define ADDR_ACT_TIME 8'h29
`define INACT_TH_BASE 8'h2A
`define ADDR_INACT_TIME_H 8'h30
`define ADDR_INACT_TIME_L 8'h31
`define ADDR_IRQ_PIN_ONE_MAP 8'h3B
`define ADDR_IRQ_PIN_TWO_MAP 8'h3C
`define ADDR_ACT_MODE 8'h3E
`define ADDR_POWER 8'h3F
`define WARN_TH_BASE 8'h41
`define CFG_BASE 8'h20
`define CFG_LAST 8'h47
`define CFG_N 40

// Threshold low byte fields
`define TH_EN_BIT 0
`define TH_REL_BIT 1

// Status fields
`define AWAKE_BIT 6
`define ST2_ACT_BIT 4
`define ST2_INACT_BIT 5
`define ST2_WARN_BIT 6

// Pin map fields
`define MAP_ACT 0
`define MAP_INACT 1
`define MAP_AWAKE 2
`define MAP_WARN 3

// Mode register fields
`define MODE_LINK_BIT 0
`define MODE_LOOP_BIT 1
`define AUTOSLEEP_BIT 2
`define FILTER_WAIT_BIT 3

// Power register fields and codes
`define ODR_FAST_BIT 2
`define PWR_CODE_STBY 2'h0
`define PWR_CODE_WAKE 2'h1
`define PWR_CODE_MEAS 2'h2

// Counter limits
`define ACT_CNT_MAX 8'hFF
`define INACT_CNT_MAX 16'hFFFF

`endif

// File: inc/motion_pkg.sv
// Types shared by the motion detector and its tick timer
`include "motion_consts.svh"
package motion_pkg;

  // Power state, one-hot
  typedef enum logic [2:0]
  {
    PWR_STBY = 3'h1,
    PWR_WAKE = 3'h2,
    PWR_MEAS = 3'h4
  } power_e;

  // Which detector the linked and loop modes expect next
  typedef enum logic [1:0]
  {
    PH_ACT = 2'h1,
    PH_INACT = 2'h2
  } phase_e;

  // One three-axis sample, two's complement per axis
  typedef struct packed
  {
    logic [2:0][11:0] axis;
  } sample_s;

  // Tick timer state
  typedef struct packed
  {
    logic [`TICK_W-1:0] cnt;
    logic tick;
  } tick_s;

  // Detector state
  typedef struct packed
  {
    logic [`CFG_N-1:0][7:0] cfg;
    power_e pwr;
    phase_e phase;
    logic as_armed;
    logic awake;
    logic act_f;
    logic inact_f;
    logic warn_f;
    logic act_run;
    logic inact_run;
    logic [7:0] act_cnt;
    logic [15:0] inact_cnt;
    logic ref_held;
    logic ref_pend;
    logic [2:0][11:0] refv;
    logic [7:0] rdata;
    logic rvalid;
    logic pin1;
    logic pin2;
  } det_s;

endpackage

// File: logic/motion_tick.sv
// Restartable period timer giving a one-cycle tick
`timescale 1ns/1ns
`default_nettype none
`include "motion_consts.svh"
module motion_tick
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Control
  input wire logic clear,
  input wire logic [`TICK_W-1:0] limit,
  // Tick out
  output logic tick
);

  motion_pkg::tick_s q;
  motion_pkg::tick_s n;

  // *****************************
  // Next state
  // *****************************
  // Clear holds the phase at zero so a new run starts a full period
  always_comb
  begin
    n = q;
    n.tick = 1'b0;
    if (clear)
    begin
      n.cnt = '0;
    end
    else if (q.cnt >= limit - `TICK_ONE)
    begin
      n.cnt = '0;
      n.tick = 1'b1;
    end
    else
    begin
      n.cnt = q.cnt + `TICK_ONE;
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
    end
    else
    begin
      q <= n;
    end
  end

  assign tick = q.tick;

endmodule
`default_nettype wire

// File: verification/host_model.sv
// Host processor model driving the detector register port
`timescale 1ns/1ns
`default_nettype none
`include "motion_consts.svh"
module host_model
(
  // Clock
  input wire logic clk_sys,
  // Register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  // ****************
  // Idle bus
  // ****************
  // Quiet port at time zero
  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end

  // ****************
  // Access tasks
  // ****************
  // Write held for one edge; idle bus then shows no stale value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
    // Idle edge so a following request never shares this time step
    @(posedge clk_sys);
    #1;
  endtask

  // Read; answer stands the whole following cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
    output logic ok);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    ok = reg_rvalid;
    d = reg_rdata;
    // Idle edge before the next request
    @(posedge clk_sys);
    #1;
  endtask

  // Power command; selecting wake-up also arms autosleep
  task automatic pw(input logic [1:0] c);
    wr(`ADDR_POWER, {6'h00, c});
  endtask

  // Reference re-arm: absolute first, referenced after settling
  task automatic rearm_ref(input int settle);
    wr(`INACT_TH_BASE + 8'h01, 8'h01);
    repeat (settle) @(posedge clk_sys);
    #1;
    wr(`INACT_TH_BASE + 8'h01, 8'h03);
  endtask
endmodule
`default_nettype wire

// File: verification/tb.sv
// Self-checking bench for the motion detector
`timescale 1ns/1ns
`default_nettype none
`include "motion_consts.svh"
module tb;
  // ****************
  // Signals
  // ****************
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic sample_valid = 1'b0;
  motion_pkg::sample_s sample = '0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, reg_rvalid, irq_pin_one, irq_pin_two;
  logic [2:0] pwr_mode;
  // Result counters
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [7:0] d;
  logic ok;
  // Setup table: thresholds 16 (x act, x/y inact), warn 64, maps
  logic [7:0] cfg_a [11] = '{8'h23, 8'h24, 8'h2A, 8'h2B, 8'h2C,
    8'h2D, 8'h41, 8'h42, 8'h3B, 8'h3C, 8'h29};
  logic [7:0] cfg_d [11] = '{8'h02, 8'h01, 8'h02, 8'h01, 8'h02,
    8'h01, 8'h08, 8'h01, 8'h04, 8'h09, 8'h05};

  // Clock at 100 MHz
  always #5 clk_sys = ~clk_sys;

  // Short tick counts keep the run brief
  motion_activity_inactivity_detector #(.ACT_TICK_CYC(24'h000014),
    .ACT_TICK_FAST_CYC(24'h00000A), .INACT_TICK_CYC(24'h000028)) i_dut
  (.clk_sys, .rst_n, .sample_valid, .sample, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .irq_pin_one,
    .irq_pin_two, .pwr_mode);

  host_model i_host
  (.clk_sys, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .reg_rvalid);

  // ****************
  // Tasks
  // ****************
  // Verdict and end of run
  task automatic report_and_stop();
    if (fail_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Compare one value
  task automatic chk(input string n, input logic [7:0] s,
    input logic [7:0] e);
    tests_run++;
    if (s !== e)
    begin
      fail_count++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask

  // Register read compare, answer must be flagged valid
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    i_host.rd(a, d, ok);
    chk("reg_rvalid", {7'h00, ok}, 8'h01);
    chk($sformatf("reg_%h", a), d, e);
  endtask

  // Power state and pin compares
  task automatic pm(input logic [2:0] e);
    chk("pwr_mode", {5'h00, pwr_mode}, {5'h00, e});
  endtask
  task automatic pins(input logic p1, input logic p2);
    chk("irq_pin_one", {7'h00, irq_pin_one}, {7'h00, p1});
    chk("irq_pin_two", {7'h00, irq_pin_two}, {7'h00, p2});
  endtask

  // One sample of x and y; z idle
  task automatic smp(input logic [11:0] x, input logic [11:0] y);
    sample.axis[0] = x;
    sample.axis[1] = y;
    sample.axis[2] = 12'h000;
    sample_valid = 1'b1;
    @(posedge clk_sys);
    #1;
    sample_valid = 1'b0;
    // Invalid sample must not look like the last one
    sample = ~sample;
    // Idle edge so back-to-back samples never share a time step
    @(posedge clk_sys);
    #1;
  endtask

  // Hang guard well above the expected run length
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      report_and_stop();
    end
  end

  // ****************
  // Main sequence
  // ****************
  initial
  begin
    repeat (3) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    @(posedge clk_sys);
    #1;
    // Reset values, read/write, read-only and unmapped places
    pm(3'h1);
    rchk(`ADDR_INACT_TIME_H, 8'h00);
    i_host.wr(`ADDR_INACT_TIME_H, 8'hA5);
    i_host.wr(`ADDR_STATUS, 8'hFF);
    rchk(`ADDR_INACT_TIME_H, 8'hA5);
    rchk(`ADDR_STATUS, 8'h00);
    rchk(8'h10, 8'h00);
    i_host.wr(`ADDR_INACT_TIME_H, 8'h00);
    foreach (cfg_a[i])
      i_host.wr(cfg_a[i], cfg_d[i]);
    // Wake-up: one sample wakes, no activity event with time 5
    i_host.pw(`PWR_CODE_WAKE);
    smp(12'h01E, 12'h000);
    pm(3'h4);
    pins(1'b1, 1'b0);
    rchk(`ADDR_STATUS, 8'h40);
    rchk(`ADDR_STATUS2, 8'h00);
    // Activity needs five sustained ticks in measurement
    repeat (3) smp(12'h01E, 12'h000);
    chk("irq_pin_two", {7'h00, irq_pin_two}, 8'h00);
    repeat (130) smp(12'h01E, 12'h000);
    chk("irq_pin_two", {7'h00, irq_pin_two}, 8'h01);
    rchk(`ADDR_STATUS2, 8'h10);
    rchk(`ADDR_STATUS2, 8'h00);
    // Inactivity: every enabled axis, one full tick
    i_host.wr(`ADDR_INACT_TIME_L, 8'h01);
    repeat (100) smp(12'h000, 12'h01E);
    smp(12'h000, 12'h000);
    rchk(`ADDR_STATUS2, 8'h00);
    repeat (60) smp(12'h000, 12'h000);
    rchk(`ADDR_STATUS2, 8'h20);
    rchk(`ADDR_STATUS, 8'h40);
    i_host.wr(`ADDR_INACT_TIME_L, 8'h00);
    // Warning: single sample, second pin only
    i_host.wr(`ADDR_IRQ_PIN_ONE_MAP, 8'h08);
    smp(12'h064, 12'h000);
    pins(1'b0, 1'b1);
    rchk(`ADDR_STATUS2, 8'h40);
    i_host.wr(`ADDR_IRQ_PIN_ONE_MAP, 8'h04);
    i_host.wr(`ADDR_ACT_TIME, 8'h00);
    // Linked: next detector armed only after service
    i_host.wr(`ADDR_ACT_MODE, 8'h01);
    i_host.pw(`PWR_CODE_WAKE);
    smp(12'h01E, 12'h000);
    smp(12'h000, 12'h000);
    rchk(`ADDR_STATUS2, 8'h10);
    smp(12'h01E, 12'h000);
    smp(12'h000, 12'h000);
    rchk(`ADDR_STATUS2, 8'h20);
    rchk(`ADDR_STATUS, 8'h00);
    pins(1'b0, 1'b0);
    // Loop: alternates with no service between
    i_host.wr(`ADDR_ACT_MODE, 8'h02);
    smp(12'h01E, 12'h000);
    smp(12'h000, 12'h000);
    rchk(`ADDR_STATUS2, 8'h30);
    rchk(`ADDR_STATUS, 8'h00);
    // Autosleep: no automatic sleep when started in measurement
    i_host.wr(`ADDR_ACT_MODE, 8'h04);
    i_host.pw(`PWR_CODE_MEAS);
    smp(12'h000, 12'h000);
    pm(3'h4);
    i_host.pw(`PWR_CODE_WAKE);
    smp(12'h01E, 12'h000);
    pm(3'h4);
    rchk(`ADDR_STATUS, 8'h40);
    smp(12'h000, 12'h000);
    pm(3'h2);
    // Absolute then referenced inactivity, then a fresh reference
    i_host.wr(`ADDR_ACT_MODE, 8'h00);
    i_host.pw(`PWR_CODE_MEAS);
    i_host.rd(`ADDR_STATUS2, d, ok);
    smp(12'h1F9, 12'h000);
    rchk(`ADDR_STATUS2, 8'h50);
    i_host.rearm_ref(4);
    smp(12'h1F4, 12'h000);
    i_host.rd(`ADDR_STATUS2, d, ok);
    smp(12'h1F9, 12'h000);
    rchk(`ADDR_STATUS2, 8'h70);
    // Re-arm in standby; only the next entry takes a new reference
    i_host.pw(`PWR_CODE_STBY);
    i_host.rearm_ref(4);
    i_host.pw(`PWR_CODE_MEAS);
    smp(12'hE0C, 12'h000);
    i_host.rd(`ADDR_STATUS2, d, ok);
    smp(12'hE07, 12'h000);
    rchk(`ADDR_STATUS2, 8'h70);
    // Fast rate: five short ticks fit in 60 cycles, long ones do not
    i_host.wr(`ADDR_ACT_TIME, 8'h05);
    i_host.wr(`ADDR_POWER, 8'h06);
    repeat (30) smp(12'h01E, 12'h000);
    rchk(`ADDR_STATUS2, 8'h10);
    report_and_stop();
  end
endmodule
`default_nettype wire
